// file: dv/ocf_capture.sv
// Capture logic model: takes output words, stalls when asked.
// Assumes the formatter output stream on core_clk.
`timescale 1ns/100ps
module ocf_capture (
	// Clock and enable.
	input wire logic core_clk,
	input wire logic clk_en,
	// Output stream.
	input wire logic out_valid,
	output logic out_ready,
	input wire ocf_pkg::ocf_code_type out_code,
	input wire logic out_range,
	// Control.
	input wire logic stall
);
	import ocf_pkg::*;
	logic [10:0] got[$];
	assign out_ready = !stall;
	always @(posedge core_clk) begin
		if (clk_en && out_valid && out_ready) begin
			got.push_back({out_range, out_code});
		end
	end
endmodule : ocf_capture

// file: dv/ocf_formatter_test.sv
// Testbench for the output code formatter.
// Assumes the design files and the capture model are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("Error at %0t: %h vs %h", $time, a, b); end end
module ocf_formatter_test;
	import ocf_pkg::*;
	logic core_clk = 0, nrst = 0, gray_sel = 0, in_valid = 0;
	logic in_over = 0, in_under = 0, stall = 0, clk_en = 1;
	ocf_code_type in_code = 10'h000, out_code;
	logic in_ready, out_valid, out_ready, out_range;
	int n_fail = 0, n_tests = 0;
	logic [10:0] exp_q[$];
	ocf_formatter i_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.gray_sel(gray_sel), .in_valid(in_valid), .in_ready(in_ready),
		.in_code(in_code), .in_over(in_over), .in_under(in_under),
		.out_valid(out_valid), .out_ready(out_ready), .out_code(out_code),
		.out_range(out_range));
	ocf_capture i_cap (.core_clk(core_clk), .clk_en(clk_en), .out_valid(out_valid),
		.out_ready(out_ready), .out_code(out_code), .out_range(out_range),
		.stall(stall));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	task put(input ocf_code_type b, input logic ov, input logic un);
		ocf_code_type w;
		int k;
		w = ov ? 10'h3FF : (un ? 10'h000 : b);
		if (gray_sel) w = w ^ (w >> 1);
		exp_q.push_back({ov | un, w});
		in_code = b;
		in_over = ov;
		in_under = un;
		in_valid = 1'b1;
		for (k = 0; k < 50 && in_ready !== 1'b1; k++) @(negedge core_clk);
		@(negedge core_clk);
	endtask : put
	task drain;
		int k;
		in_valid = 1'b0;
		for (k = 0; k < 50 && i_cap.got.size() < exp_q.size(); k++) @(negedge core_clk);
		`CHK(i_cap.got.size(), exp_q.size())
		for (k = 0; k < exp_q.size(); k++) `CHK(i_cap.got[k], exp_q[k])
		i_cap.got.delete();
		exp_q.delete();
	endtask : drain
	task codes;
		ocf_code_type pts[6] = '{10'h200, 10'h300, 10'h100, 10'h001, 10'h3FF, 10'h155};
		foreach (pts[i]) put(pts[i], 1'b0, 1'b0);
		put(10'h155, 1'b1, 1'b0);
		put(10'h2AA, 1'b0, 1'b1);
		put(10'h000, 1'b1, 1'b1);
		drain();
	endtask : codes
	task t_bin;
		codes();
	endtask : t_bin
	task t_freeze;
		put(10'h0AA, 1'b0, 1'b0);
		clk_en = 1'b0;
		in_valid = 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK(out_valid, 1'b1)
		`CHK(out_code, 10'h0AA)
		`CHK(i_cap.got.size(), 0)
		clk_en = 1'b1;
		drain();
	endtask : t_freeze
	task t_reset;
		stall = 1'b1;
		put(10'h123, 1'b0, 1'b0);
		in_valid = 1'b0;
		nrst = 1'b0;
		@(negedge core_clk);
		nrst = 1'b1;
		exp_q.delete();
		`CHK(out_valid, 1'b0)
		`CHK(in_ready, 1'b1)
		stall = 1'b0;
		in_code = 10'h300;
		in_valid = 1'b1;
		exp_q.push_back({1'b0, 10'h300});
		@(negedge core_clk);
		exp_q.push_back({1'b0, 10'h300});
		@(negedge core_clk);
		exp_q.push_back({1'b0, 10'h280});
		@(negedge core_clk);
		drain();
	endtask : t_reset
	task t_gray;
		gray_sel = 1'b1;
		repeat (4) @(negedge core_clk);
		codes();
	endtask : t_gray
	task t_stall;
		stall = 1'b1;
		put(10'h3FE, 1'b0, 1'b0);
		put(10'h001, 1'b1, 1'b0);
		`CHK(in_ready, 1'b0)
		`CHK(out_valid, 1'b1)
		fork
			put(10'h002, 1'b0, 1'b1);
			begin
				repeat (5) @(negedge core_clk);
				stall = 1'b0;
			end
		join
		drain();
	endtask : t_stall
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		n_fail++;
		give_verdict();
	end
	initial begin
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		t_bin();
		t_freeze();
		t_stall();
		t_gray();
		t_reset();
		give_verdict();
	end
endmodule : ocf_formatter_test

// file: hdl/ocf_defines.svh
// Constants for the converter output code formatter.
// Assumes inclusion by bare name from the package and the design module.
`ifndef OCF_DEFINES_SVH
`define OCF_DEFINES_SVH
`define OCF_CODE_W 10
`define OCF_CODE_MAX 10'h3FF
`define OCF_CODE_MIN 10'h000
`define OCF_FMT_BINARY 1'b0
`define OCF_FMT_GRAY 1'b1
`define OCF_BUF_DEPTH 2
`endif

// file: hdl/ocf_formatter.sv
// Output code formatter: saturation, binary or Gray coding, two-entry output buffer.
// Assumes the converter core and capture logic run on core_clk; format select is a pin.
`timescale 1ns/100ps
`include "ocf_defines.svh"
module ocf_formatter (
	// Clock, reset, enable.
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Format select pin, asynchronous.
	input wire logic gray_sel,
	// Converter core side.
	input wire logic in_valid,
	output logic in_ready,
	input wire ocf_pkg::ocf_code_type in_code,
	input wire logic in_over,
	input wire logic in_under,
	// Capture side.
	output logic out_valid,
	input wire logic out_ready,
	output ocf_pkg::ocf_code_type out_code,
	output logic out_range
);
	import ocf_pkg::*;

	// ----------------------------------------
	// Code conversion
	// ----------------------------------------
	function automatic ocf_code_type ocf_to_gray(input ocf_code_type b);
		ocf_to_gray = b ^ (b >> 1);
	endfunction : ocf_to_gray

	// ----------------------------------------
	// Format select synchroniser
	// ----------------------------------------
	logic sel_s1_reg, sel_s1_next;
	logic sel_s2_reg, sel_s2_next;
	ocf_fmt_type fmt;

	always_comb begin
		sel_s1_next = gray_sel;
		sel_s2_next = sel_s1_reg;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sel_s1_reg <= `OCF_FMT_BINARY;
			sel_s2_reg <= `OCF_FMT_BINARY;
		end else if (clk_en) begin
			sel_s1_reg <= sel_s1_next;
			sel_s2_reg <= sel_s2_next;
		end
	end

	assign fmt = ocf_fmt_type'(sel_s2_reg);

	// ----------------------------------------
	// Saturation and coding
	// ----------------------------------------
	ocf_code_type sat_code;
	ocf_code_type fmt_code;
	logic sat_flag;

	always_comb begin
		sat_flag = in_over | in_under;
		if (in_over) begin
			sat_code = `OCF_CODE_MAX;
		end else if (in_under) begin
			sat_code = `OCF_CODE_MIN;
		end else begin
			sat_code = in_code;
		end
		if (fmt == OCF_FMT_GRY) begin
			fmt_code = ocf_to_gray(sat_code);
		end else begin
			fmt_code = sat_code;
		end
	end

	// ----------------------------------------
	// Two-entry buffer
	// ----------------------------------------
	ocf_code_type code_mem_reg [`OCF_BUF_DEPTH];
	ocf_code_type code_mem_next [`OCF_BUF_DEPTH];
	logic [`OCF_BUF_DEPTH-1:0] flag_mem_reg, flag_mem_next;
	logic [1:0] cnt_reg, cnt_next;
	logic wr_ptr_reg, wr_ptr_next;
	logic rd_ptr_reg, rd_ptr_next;
	logic in_ready_reg, in_ready_next;
	logic out_valid_reg, out_valid_next;
	ocf_code_type out_code_reg, out_code_next;
	logic out_range_reg, out_range_next;
	logic push, pop;

	always_comb begin
		push = in_valid & in_ready_reg;
		pop = out_valid_reg & out_ready;
		code_mem_next = code_mem_reg;
		flag_mem_next = flag_mem_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		cnt_next = cnt_reg;
		if (push) begin
			code_mem_next[wr_ptr_reg] = fmt_code;
			flag_mem_next[wr_ptr_reg] = sat_flag;
			wr_ptr_next = ~wr_ptr_reg;
		end
		if (pop) begin
			rd_ptr_next = ~rd_ptr_reg;
		end
		cnt_next = cnt_reg + 2'(push) - 2'(pop);
		in_ready_next = (cnt_next != 2'h2);
		out_valid_next = (cnt_next != 2'h0);
		out_code_next = code_mem_next[rd_ptr_next];
		out_range_next = flag_mem_next[rd_ptr_next];
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			code_mem_reg <= '{default: `OCF_CODE_MIN};
			flag_mem_reg <= '0;
			cnt_reg <= 2'h0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			in_ready_reg <= 1'b1;
			out_valid_reg <= 1'b0;
			out_code_reg <= `OCF_CODE_MIN;
			out_range_reg <= 1'b0;
		end else if (clk_en) begin
			code_mem_reg <= code_mem_next;
			flag_mem_reg <= flag_mem_next;
			cnt_reg <= cnt_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			in_ready_reg <= in_ready_next;
			out_valid_reg <= out_valid_next;
			out_code_reg <= out_code_next;
			out_range_reg <= out_range_next;
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	assign in_ready = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_code = out_code_reg;
	assign out_range = out_range_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_OVER_CODE: assert property (@(posedge core_clk) disable iff (!nrst)
		(push && in_over && fmt == OCF_FMT_BIN) |-> fmt_code == 10'h3FF && sat_flag)
		else $error("Over-range sample not coded as all ones with flag.");
	AST_OVER_GRAY: assert property (@(posedge core_clk) disable iff (!nrst)
		(push && in_over && fmt == OCF_FMT_GRY) |-> fmt_code == 10'h200 && sat_flag)
		else $error("Over-range sample not coded as Gray top with flag.");
	AST_UNDER_CODE: assert property (@(posedge core_clk) disable iff (!nrst)
		(push && in_under && !in_over) |-> fmt_code == 10'h000 && sat_flag)
		else $error("Under-range sample not coded as zero with flag.");
	AST_TOP_IN: assert property (@(posedge core_clk) disable iff (!nrst)
		(push && !sat_flag && in_code == 10'h3FF && fmt == OCF_FMT_GRY) |-> fmt_code == 10'h200)
		else $error("Top in-range code wrong in Gray.");
	AST_LOW_IN: assert property (@(posedge core_clk) disable iff (!nrst)
		(push && !sat_flag && in_code == 10'h001) |-> fmt_code == 10'h001 && !sat_flag)
		else $error("Lowest in-range code wrong.");
	AST_BIN_PASS: assert property (@(posedge core_clk) disable iff (!nrst)
		(!sat_flag && fmt == OCF_FMT_BIN) |-> fmt_code == in_code)
		else $error("Binary code does not follow input.");
	AST_GRAY_MID: assert property (@(posedge core_clk) disable iff (!nrst)
		(!sat_flag && fmt == OCF_FMT_GRY && in_code == 10'h300) |-> fmt_code == 10'h280)
		else $error("Gray code of three-quarter scale wrong.");
	AST_GRAY_HALF: assert property (@(posedge core_clk) disable iff (!nrst)
		(!sat_flag && fmt == OCF_FMT_GRY && in_code == 10'h200) |-> fmt_code == 10'h300)
		else $error("Gray code of mid scale wrong.");
	AST_GRAY_QUARTER: assert property (@(posedge core_clk) disable iff (!nrst)
		(!sat_flag && fmt == OCF_FMT_GRY && in_code == 10'h100) |-> fmt_code == 10'h180)
		else $error("Gray code of one-quarter scale wrong.");
	AST_RESET_BIN: assert property (@(posedge core_clk)
		!nrst |=> fmt == OCF_FMT_BIN)
		else $error("Format not binary after reset.");
	AST_PAIR: assert property (@(posedge core_clk) disable iff (!nrst)
		(clk_en && push && cnt_reg == 2'h0 && !pop) |=>
		out_valid && out_code == $past(fmt_code) && out_range == $past(sat_flag))
		else $error("Data word and flag not presented together.");
	AST_NO_OVERFLOW: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_reg != 2'h3)
		else $error("Buffer count out of range.");

	// ----------------------------------------
	// Buffer and control checks
	// ----------------------------------------
	AST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
		(clk_en && out_valid && !out_ready) |=>
		out_valid && $stable(out_code) && $stable(out_range))
		else $error("Stalled word or flag changed before it was taken.");
	AST_REFUSE: assert property (@(posedge core_clk) disable iff (!nrst)
		(clk_en && in_valid && !in_ready && !out_ready) |=>
		!in_ready && $stable(cnt_reg))
		else $error("Sample stored while the buffer was full.");
	AST_FREEZE: assert property (@(posedge core_clk) disable iff (!nrst)
		!clk_en |=>
		$stable(cnt_reg) && $stable(out_valid) && $stable(out_code) && $stable(sel_s2_reg))
		else $error("State changed while the clock enable was low.");
	AST_EMPTY_STATE: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_reg == 2'h0 |-> in_ready && !out_valid)
		else $error("Empty buffer flags wrong.");
	AST_FULL_STATE: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_reg == 2'h2 |-> !in_ready && out_valid)
		else $error("Full buffer flags wrong.");
	AST_RESET_OUT: assert property (@(posedge core_clk)
		!nrst |=> !out_valid && in_ready && !out_range && out_code == `OCF_CODE_MIN)
		else $error("Outputs not at reset values after reset.");
	AST_SYNC_CHAIN: assert property (@(posedge core_clk) disable iff (!nrst)
		clk_en |=> sel_s2_reg == $past(sel_s1_reg))
		else $error("Format select synchroniser skipped a stage.");
endmodule : ocf_formatter

// file: hdl/ocf_pkg.sv
// Types for the converter output code formatter.
// Assumes the defines header is on the include path.
`include "ocf_defines.svh"
package ocf_pkg;
	typedef logic [`OCF_CODE_W-1:0] ocf_code_type;
	typedef enum logic {
		OCF_FMT_BIN = `OCF_FMT_BINARY,
		OCF_FMT_GRY = `OCF_FMT_GRAY
	} ocf_fmt_type;
endpackage : ocf_pkg
